// [shared/rtcc_pkg.sv]
package rtcc_pkg;
    localparam int XTAL_HZ = 32768;
    localparam int CHR_HZ = 128;
    localparam int CHR_DIV = XTAL_HZ / CHR_HZ;
    localparam logic [15:0] SEC_DIV = 16'(XTAL_HZ);
    localparam logic [7:0] CHR_MASK = 8'(CHR_DIV - 1);
    localparam logic [3:0] COMP_LAST_SLOT = 4'he;
    localparam logic [5:0] COMP_SPLIT = 6'h0f;
    localparam logic [11:0] CHR_SCALE = 12'h019;
    localparam logic [11:0] CHR_ROUND = 12'h010;
    localparam int CHR_SHIFT = 5;

    localparam int APB_AW = 12;
    localparam logic [9:0] IDX_PROTECT = 10'h040;
    localparam logic [9:0] IDX_COMP = 10'h041;
    localparam logic [9:0] IDX_CTRL_ONE = 10'h042;
    localparam logic [9:0] IDX_CTRL_TWO = 10'h043;
    localparam logic [9:0] IDX_STATUS = 10'h044;
    localparam logic [9:0] IDX_ALARM_MIN = 10'h045;
    localparam logic [9:0] IDX_ALARM_HOUR = 10'h046;
    localparam logic [9:0] IDX_SECONDS = 10'h047;
    localparam logic [9:0] IDX_MINUTES = 10'h048;
    localparam logic [9:0] IDX_HOURS = 10'h049;
    localparam logic [9:0] IDX_DAY = 10'h04a;
    localparam logic [9:0] IDX_MONTH = 10'h04b;
    localparam logic [9:0] IDX_YEAR = 10'h04c;
    localparam logic [9:0] IDX_WEEKDAY = 10'h04d;
    localparam logic [9:0] IDX_CHRON = 10'h04e;

    // Status and enable bit positions are shared by both registers.
    localparam int BIT_ALARM = 7;
    localparam int BIT_CHRON = 6;
    localparam int BIT_DAY = 5;
    localparam int BIT_HOUR = 4;
    localparam int BIT_MINUTE = 3;
    localparam int BIT_SECOND = 2;
    localparam int BIT_TB_ONE = 1;
    localparam int BIT_TB_TWO = 0;
    localparam int BIT_COMP_EN = 7;
    localparam int BIT_CHR_CLEAR = 6;
    localparam int BIT_CHR_EN = 5;
    localparam int BIT_MODULE_EN = 4;
    localparam int BIT_TB_GROUP = 3;
    localparam int BIT_PROTECT = 0;

    localparam logic [7:0] MASK_MINUTE = 8'h3f;
    localparam logic [7:0] MASK_HOUR = 8'h1f;
    localparam logic [7:0] MASK_MONTH = 8'h0f;
    localparam logic [7:0] MASK_WEEKDAY = 8'h07;
    localparam logic [7:0] MASK_COMP = 8'h3f;
    localparam logic [7:0] SEC_LAST = 8'h3b;
    localparam logic [7:0] MIN_LAST = 8'h3b;
    localparam logic [7:0] HR_LAST = 8'h17;
    localparam logic [7:0] MON_LAST = 8'h0c;
    localparam logic [7:0] YR_LAST = 8'hc7;
    localparam logic [7:0] WD_LAST = 8'h06;
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_FIRST = 8'h01;

    typedef struct packed {
        logic second;
        logic chron;
        logic tb_one;
        logic tb_two;
    } rtcc_ticks_t;

    function automatic logic [7:0] rtcc_step(input logic [7:0] v, input logic [7:0] last,
                                             input logic [7:0] first);
        return (v >= last) ? first : 8'(v + 8'h01);
    endfunction

    // Year holds years past 1900, so its low bits carry divisibility by four.
    function automatic logic [7:0] rtcc_month_days(input logic [7:0] month,
                                                   input logic [7:0] year);
        logic [7:0] days;
        days = 8'h1f;
        if (month == 8'h04 || month == 8'h06 || month == 8'h09 || month == 8'h0b) begin
            days = 8'h1e;
        end else if (month == 8'h02) begin
            days = (year[1:0] == 2'b00) ? 8'h1d : 8'h1c;
        end
        return days;
    endfunction
endpackage

// [design/rtcc_prescaler.sv]
`timescale 1ns/1ps
module rtcc_prescaler import rtcc_pkg::*; (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control
    input wire logic module_enable,
    input wire logic timebase_group_select,
    input wire logic comp_enable,
    input wire logic [5:0] comp_value,
    // Crystal and derived ticks
    input wire logic crystal_clock,
    output rtcc_ticks_t ticks
);
    logic xtal_q;
    logic rise;
    logic [14:0] free_cnt;
    logic [15:0] sec_div;
    logic [15:0] limit;
    logic [3:0] comp_slot;
    logic [5:0] mag;
    logic [1:0] adjust;
    logic sec_end;

    assign rise = module_enable & crystal_clock & ~xtal_q;
    assign mag = comp_value[5] ? 6'(-comp_value) : comp_value;
    assign limit = comp_value[5] ? 16'(SEC_DIV - 16'(adjust)) : 16'(SEC_DIV + 16'(adjust));
    assign sec_end = sec_div == 16'(limit - 16'h0001);

    // The error is spread over a fifteen-second window, at most two cycles per second.
    always_comb begin
        adjust = 2'h0;
        if (comp_enable && mag != 6'h00) begin
            if (mag <= COMP_SPLIT) begin
                adjust = ({2'b00, comp_slot} < mag) ? 2'h1 : 2'h0;
            end else begin
                adjust = ({2'b00, comp_slot} < 6'(mag - COMP_SPLIT)) ? 2'h2 : 2'h1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xtal_q <= 1'b0;
        end else begin
            xtal_q <= crystal_clock;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            free_cnt <= 15'h0000;
            sec_div <= 16'h0000;
            comp_slot <= 4'h0;
        end else if (!module_enable) begin
            free_cnt <= 15'h0000;
            sec_div <= 16'h0000;
            comp_slot <= 4'h0;
        end else if (rise) begin
            free_cnt <= 15'(free_cnt + 15'h0001);
            sec_div <= sec_end ? 16'h0000 : 16'(sec_div + 16'h0001);
            if (sec_end) begin
                comp_slot <= (comp_slot == COMP_LAST_SLOT) ? 4'h0 : 4'(comp_slot + 4'h1);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ticks <= '0;
        end else begin
            ticks.second <= rise & sec_end;
            ticks.chron <= rise & (free_cnt[7:0] == CHR_MASK);
            ticks.tb_one <= rise & (timebase_group_select ? &free_cnt[11:0]
                                                          : &free_cnt[13:0]);
            ticks.tb_two <= rise & (timebase_group_select ? &free_cnt[10:0]
                                                          : &free_cnt[12:0]);
        end
    end
endmodule

// [design/rtcc_chrono.sv]
`timescale 1ns/1ps
module rtcc_chrono import rtcc_pkg::*; (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control
    input wire logic step,
    input wire logic run,
    input wire logic clear,
    // Result
    output logic [6:0] hundredths,
    output logic stepped
);
    logic [6:0] count;
    logic [11:0] scaled;

    assign stepped = run & step & ~clear;
    assign scaled = 12'(12'(count) * CHR_SCALE + CHR_ROUND);

    // A 7-bit count wraps at 128 steps, which maps to hundredths 99 back to 0.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= 7'h00;
        end else if (clear) begin
            count <= 7'h00;
        end else if (stepped) begin
            count <= 7'(count + 7'h01);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hundredths <= 7'h00;
        end else begin
            hundredths <= 7'(scaled >> CHR_SHIFT);
        end
    end
endmodule

// [design/rtcc_top.sv]
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
module rtcc_top import rtcc_pkg::*; (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Crystal input
    input wire logic crystal_clock,
    // Request lines, one per status flag
    output logic [7:0] irq_request
);
    logic [9:0] idx;
    logic aligned;
    logic setup;
    logic access;
    logic wr_en;
    logic cnt_wr;
    logic [7:0] wdata;

    logic write_protect;
    logic [5:0] comp_value;
    logic [7:0] control_one;
    logic comp_enable;
    logic chr_enable;
    logic module_enable;
    logic timebase_group_select;
    logic chr_clear;

    logic [7:0] status;
    logic [7:0] set_flags;
    logic [7:0] clr_flags;

    logic [7:0] alarm_minute;
    logic [7:0] alarm_hour;
    logic [7:0] seconds_count;
    logic [7:0] minutes_count;
    logic [7:0] hours_count;
    logic [7:0] day_of_month_count;
    logic [7:0] month_count;
    logic [7:0] year_count;
    logic [7:0] weekday_count;
    logic [7:0] month_days;
    logic match;
    logic match_q;

    rtcc_ticks_t ticks;
    logic [6:0] hundredths;
    logic chr_stepped;
    logic min_inc;
    logic hr_inc;
    logic day_inc;
    logic mon_inc;
    logic yr_inc;

    logic [7:0] rd_value;
    logic rd_hit;

    assign idx = paddr[11:2];
    assign aligned = paddr[1:0] == 2'b00;
    assign setup = psel & ~penable;
    assign access = psel & penable;
    assign wr_en = access & pwrite & aligned;
    assign cnt_wr = wr_en & ~write_protect;
    assign wdata = pwdata[7:0];
    assign pready = 1'b1;
    assign chr_clear = wr_en && idx == IDX_CTRL_TWO && wdata[BIT_CHR_CLEAR];

    rtcc_prescaler u_prescaler (
        .pclk(pclk),
        .presetn(presetn),
        .module_enable(module_enable),
        .timebase_group_select(timebase_group_select),
        .comp_enable(comp_enable),
        .comp_value(comp_value),
        .crystal_clock(crystal_clock),
        .ticks(ticks)
    );

    rtcc_chrono u_chrono (
        .pclk(pclk),
        .presetn(presetn),
        .step(ticks.chron),
        .run(chr_enable),
        .clear(chr_clear),
        .hundredths(hundredths),
        .stepped(chr_stepped)
    );

    // Control registers. Here protection guards only the compensation and module enable bits, not the compensation value; it also guards the time counters.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            write_protect <= 1'b0;
            comp_value <= 6'h00;
            control_one <= 8'h00;
            comp_enable <= 1'b0;
            chr_enable <= 1'b0;
            module_enable <= 1'b0;
            timebase_group_select <= 1'b0;
        end else if (wr_en) begin
            if (idx == IDX_PROTECT) begin
                write_protect <= wdata[BIT_PROTECT];
            end
            if (idx == IDX_COMP) begin
                comp_value <= 6'(wdata & MASK_COMP);
            end
            if (idx == IDX_CTRL_ONE) begin
                control_one <= wdata;
            end
            if (idx == IDX_CTRL_TWO) begin
                chr_enable <= wdata[BIT_CHR_EN];
                timebase_group_select <= wdata[BIT_TB_GROUP];
                if (!write_protect) begin
                    comp_enable <= wdata[BIT_COMP_EN];
                    module_enable <= wdata[BIT_MODULE_EN];
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alarm_minute <= RST_ZERO;
            alarm_hour <= RST_ZERO;
        end else if (wr_en) begin
            if (idx == IDX_ALARM_MIN) begin
                alarm_minute <= wdata & MASK_MINUTE;
            end
            if (idx == IDX_ALARM_HOUR) begin
                alarm_hour <= wdata & MASK_HOUR;
            end
        end
    end

    // Carry chain. A write in the same cycle as a tick wins for that counter only.
    assign month_days = rtcc_month_days(month_count, year_count);
    assign min_inc = ticks.second & (seconds_count >= SEC_LAST);
    assign hr_inc = min_inc & (minutes_count >= MIN_LAST);
    assign day_inc = hr_inc & (hours_count >= HR_LAST);
    assign mon_inc = day_inc & (day_of_month_count >= month_days);
    assign yr_inc = mon_inc & (month_count >= MON_LAST);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seconds_count <= RST_ZERO;
            minutes_count <= RST_ZERO;
            hours_count <= RST_ZERO;
        end else begin
            if (cnt_wr && idx == IDX_SECONDS) begin
                seconds_count <= wdata & MASK_MINUTE;
            end else if (ticks.second) begin
                seconds_count <= rtcc_step(seconds_count, SEC_LAST, RST_ZERO);
            end
            if (cnt_wr && idx == IDX_MINUTES) begin
                minutes_count <= wdata & MASK_MINUTE;
            end else if (min_inc) begin
                minutes_count <= rtcc_step(minutes_count, MIN_LAST, RST_ZERO);
            end
            if (cnt_wr && idx == IDX_HOURS) begin
                hours_count <= wdata & MASK_HOUR;
            end else if (hr_inc) begin
                hours_count <= rtcc_step(hours_count, HR_LAST, RST_ZERO);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            day_of_month_count <= RST_FIRST;
            month_count <= RST_FIRST;
            year_count <= RST_FIRST;
            weekday_count <= RST_ZERO;
        end else begin
            if (cnt_wr && idx == IDX_DAY) begin
                day_of_month_count <= wdata & MASK_HOUR;
            end else if (day_inc) begin
                day_of_month_count <= rtcc_step(day_of_month_count, month_days,
                                                RST_FIRST);
            end
            if (cnt_wr && idx == IDX_MONTH) begin
                month_count <= wdata & MASK_MONTH;
            end else if (mon_inc) begin
                month_count <= rtcc_step(month_count, MON_LAST, RST_FIRST);
            end
            // Year counts past 1900 and wraps from 2099 back to 1901.
            if (cnt_wr && idx == IDX_YEAR) begin
                year_count <= wdata;
            end else if (yr_inc) begin
                year_count <= rtcc_step(year_count, YR_LAST, RST_FIRST);
            end
            if (cnt_wr && idx == IDX_WEEKDAY) begin
                weekday_count <= wdata & MASK_WEEKDAY;
            end else if (day_inc) begin
                weekday_count <= rtcc_step(weekday_count, WD_LAST, RST_ZERO);
            end
        end
    end

    // The alarm fires on entry into a match, so a cleared flag stays clear for the
    // rest of the matching minute.
    assign match = (minutes_count == alarm_minute) && (hours_count == alarm_hour);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            match_q <= 1'b1;
        end else begin
            match_q <= match;
        end
    end

    always_comb begin
        set_flags = 8'h00;
        set_flags[BIT_ALARM] = match & ~match_q;
        set_flags[BIT_CHRON] = chr_stepped;
        set_flags[BIT_DAY] = day_inc;
        set_flags[BIT_HOUR] = hr_inc;
        set_flags[BIT_MINUTE] = min_inc;
        set_flags[BIT_SECOND] = ticks.second;
        set_flags[BIT_TB_ONE] = ticks.tb_one;
        set_flags[BIT_TB_TWO] = ticks.tb_two;
    end

    assign clr_flags = (wr_en && idx == IDX_STATUS) ? wdata : 8'h00;

    // Write one to clear; a flag raised in the clearing cycle survives.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status <= 8'h00;
        end else begin
            status <= (status & ~clr_flags) | set_flags;
        end
    end

    assign irq_request = status & control_one;

    always_comb begin
        rd_value = 8'h00;
        rd_hit = 1'b1;
        unique case (idx)
            IDX_PROTECT: rd_value[BIT_PROTECT] = write_protect;
            IDX_COMP: rd_value = {2'b00, comp_value};
            IDX_CTRL_ONE: rd_value = control_one;
            IDX_CTRL_TWO: begin
                rd_value[BIT_COMP_EN] = comp_enable;
                rd_value[BIT_CHR_EN] = chr_enable;
                rd_value[BIT_MODULE_EN] = module_enable;
                rd_value[BIT_TB_GROUP] = timebase_group_select;
            end
            IDX_STATUS: rd_value = status;
            IDX_ALARM_MIN: rd_value = alarm_minute;
            IDX_ALARM_HOUR: rd_value = alarm_hour;
            IDX_SECONDS: rd_value = seconds_count;
            IDX_MINUTES: rd_value = minutes_count;
            IDX_HOURS: rd_value = hours_count;
            IDX_DAY: rd_value = day_of_month_count;
            IDX_MONTH: rd_value = month_count;
            IDX_YEAR: rd_value = year_count;
            IDX_WEEKDAY: rd_value = weekday_count;
            IDX_CHRON: rd_value = {1'b0, hundredths};
            default: rd_hit = 1'b0;
        endcase
    end

    // Read data is caught in the setup cycle so that it comes from flip-flops.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (setup) begin
            prdata <= {24'h000000, aligned ? rd_value : 8'h00};
            pslverr <= ~(rd_hit & aligned);
        end
    end
endmodule

// [tb/rtcc_monitor.sv]
`timescale 1ns/1ps
module rtcc_monitor import rtcc_pkg::*; (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [APB_AW-1:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    // Crystal and requests
    input wire logic crystal_clock,
    input wire logic [7:0] irq_request
);
    logic rd;
    logic ctl_wr;
    logic xtal_prev;
    logic [7:0] since_xtal;
    assign rd = psel && !penable && !pwrite;
    assign ctl_wr = psel && penable && pwrite && (paddr == 12'h108 || paddr == 12'h110);
    // Ages the last crystal edge, so a new request can be traced back to a tick.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xtal_prev <= 1'b0;
            since_xtal <= 8'hff;
        end else begin
            xtal_prev <= crystal_clock;
            if (crystal_clock && !xtal_prev) begin
                since_xtal <= 8'h00;
            end else if (since_xtal != 8'hff) begin
                since_xtal <= since_xtal + 8'h01;
            end
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_upper_zero;
        prdata[31:8] == 24'h0;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");
    property p_mapped_ok;
        rd && paddr[11:2] >= IDX_PROTECT && paddr[11:2] <= IDX_CHRON && paddr[1:0] == 2'b00
            |=> !pslverr;
    endproperty
    a_mapped_ok: assert property (p_mapped_ok) else $error("mapped read refused");
    property p_unmapped_err;
        rd && paddr[11:2] < IDX_PROTECT |=> pslverr && prdata == 32'h0;
    endproperty
    a_unmapped_err: assert property (p_unmapped_err) else $error("unmapped read accepted");
    property p_sec_range;
        rd && (paddr == 12'h11c || paddr == 12'h120) |=> prdata <= 32'd59;
    endproperty
    a_sec_range: assert property (p_sec_range) else $error("seconds or minutes too big");
    property p_hour_range;
        rd && paddr == 12'h124 |=> prdata <= 32'd23;
    endproperty
    a_hour_range: assert property (p_hour_range) else $error("hours too big");
    property p_day_range;
        rd && paddr == 12'h128 |=> prdata >= 32'd1 && prdata <= 32'd31;
    endproperty
    a_day_range: assert property (p_day_range) else $error("day out of range");
    property p_year_range;
        rd && paddr == 12'h130 |=> prdata >= 32'd1 && prdata <= 32'd199;
    endproperty
    a_year_range: assert property (p_year_range) else $error("year out of range");
    property p_chr_range;
        rd && paddr == 12'h138 |=> prdata <= 32'd99;
    endproperty
    a_chr_range: assert property (p_chr_range) else $error("hundredths above 99");
    property p_irq_hold;
        |($past(irq_request) & ~irq_request) |-> $past(ctl_wr);
    endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("request dropped by itself");
    property p_irq_cause;
        |(irq_request[6:0] & ~$past(irq_request[6:0])) |-> since_xtal <= 8'd8 || $past(ctl_wr);
    endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("request without tick");
endmodule
bind rtcc_top rtcc_monitor u_monitor (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .prdata(prdata),
    .pslverr(pslverr),
    .crystal_clock(crystal_clock),
    .irq_request(irq_request)
);

// [tb/rtc_time_calendar_alarm_test.sv]
`timescale 1ns/1ps
module rtc_time_calendar_alarm_test import rtcc_pkg::*; ();
    logic pclk, presetn, psel, penable, pwrite, crystal_clock, pready, pslverr, xtal_on, err;
    logic [APB_AW-1:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0] irq_request, seed, v;
    int errors, cmp_count, xtal_edges, t0, t1, nd, i, k;
    int lim[9] = '{60, 24, 60, 60, 24, 28, 12, 199, 7};
    int base[9] = '{0, 0, 0, 0, 0, 1, 1, 1, 0};
    int roll[9] = '{0, 0, 59, 59, 23, 29, 2, 4, 6};
    int aft[9];
    rtcc_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .crystal_clock(crystal_clock), .irq_request(irq_request));
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        if (xtal_on) begin
            crystal_clock <= ~crystal_clock;
            xtal_edges <= xtal_edges + (crystal_clock ? 0 : 1);
        end
    end
    function automatic logic [7:0] lfsr(input logic [7:0] x);
        return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
    endfunction
    function automatic int days_in(input int m, input int y);
        if (m == 2) return (y % 4 == 0) ? 29 : 28;
        return (m == 4 || m == 6 || m == 9 || m == 11) ? 30 : 31;
    endfunction
    task automatic complete_run;
        if (errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic check_reg(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic check_irq(input logic [7:0] exp, input logic [7:0] mask);
        @(negedge pclk);
        check_reg("irq_request", {24'h0, exp}, {24'h0, irq_request & mask});
        @(posedge pclk);
    endtask
    task automatic apb(input logic [11:0] a, input logic w, input logic [7:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            errors++;
            complete_run;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wait_irq(input int b, output int at);
        int n;
        n = 0;
        do begin
            @(negedge pclk);
            n++;
        end while (irq_request[b] !== 1'b1 && n < 70000);
        if (n >= 70000) begin
            errors++;
            complete_run;
        end
        at = xtal_edges;
        @(posedge pclk);
    endtask
    initial begin
        {presetn, psel, penable, pwrite, crystal_clock, xtal_on} = 6'h00;
        paddr = '0;
        pwdata = '0;
        {errors, cmp_count, xtal_edges} = {32'd0, 32'd0, 32'd0};
        seed = 8'h60;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check_irq(8'h00, 8'hff);
        for (i = 0; i < 9; i++) begin
            apb(12'h114 + 12'(4 * i), 1'b0, 8'h00);
            check_reg("reset value", 32'(base[i]), rd);
        end
        apb(12'h138, 1'b1, 8'h55);
        apb(12'h138, 1'b0, 8'h00);
        check_reg("hundredths", 32'h0, rd);
        apb(12'h000, 1'b0, 8'h00);
        check_reg("unmapped error", 32'h1, {31'h0, err});
        for (k = 0; k < 18; k++) begin
            seed = lfsr(seed);
            v = 8'(seed % lim[k % 9] + base[k % 9]);
            apb(12'h114 + 12'(4 * (k % 9)), 1'b1, v);
            apb(12'h114 + 12'(4 * (k % 9)), 1'b0, 8'h00);
            check_reg("readback", {24'h0, v}, rd);
        end
        apb(12'h11c, 1'b1, 8'd10);
        apb(12'h100, 1'b1, 8'h01);
        apb(12'h11c, 1'b1, 8'd20);
        apb(12'h11c, 1'b0, 8'h00);
        check_reg("protected seconds", 32'd10, rd);
        apb(12'h100, 1'b1, 8'h00);
        for (i = 0; i < 9; i++) apb(12'h114 + 12'(4 * i), 1'b1, 8'(roll[i]));
        nd = (roll[5] >= days_in(roll[6], roll[7])) ? 1 : roll[5] + 1;
        aft = '{0, 0, 0, 0, 0, nd, (nd == 1) ? 3 : 2, 4, 0};
        apb(12'h110, 1'b1, 8'hff);
        apb(12'h108, 1'b1, 8'hf7);
        apb(12'h10c, 1'b1, 8'h10);
        xtal_on <= 1'b1;
        wait_irq(0, t0);
        apb(12'h110, 1'b1, 8'h01);
        wait_irq(0, t1);
        check_reg("four hertz", 32'd8192, 32'(t1 - t0));
        wait_irq(2, t0);
        for (i = 2; i < 9; i++) begin
            apb(12'h114 + 12'(4 * i), 1'b0, 8'h00);
            check_reg("rollover", 32'(aft[i]), rd);
        end
        check_irq(8'hb4, 8'hfc);
        apb(12'h110, 1'b0, 8'h00);
        check_reg("status", 32'hbc, rd & 32'hfc);
        apb(12'h110, 1'b1, 8'hfc);
        check_irq(8'h00, 8'hfc);
        apb(12'h10c, 1'b1, 8'h18);
        apb(12'h108, 1'b1, 8'h03);
        for (k = 0; k < 2; k++) begin
            apb(12'h110, 1'b1, 8'h03);
            wait_irq(k, t0);
            apb(12'h110, 1'b1, 8'h03);
            wait_irq(k, t1);
            // Bit 0 is the 16 Hz flag and bit 1 the 8 Hz flag in the fast group.
            check_reg("fast timebase", 32'(2048 << k), 32'(t1 - t0));
        end
        apb(12'h108, 1'b1, 8'h40);
        apb(12'h10c, 1'b1, 8'h78);
        apb(12'h110, 1'b1, 8'h40);
        for (k = 1; k < 6; k++) begin
            wait_irq(6, t1);
            if (k > 1) check_reg("chrono step", 32'd256, 32'(t1 - t0));
            t0 = t1;
            apb(12'h110, 1'b1, 8'h40);
            apb(12'h138, 1'b0, 8'h00);
            check_reg("hundredths", 32'((k * 25 + 16) / 32), rd);
        end
        apb(12'h10c, 1'b1, 8'h18);
        repeat (1200) @(posedge pclk);
        apb(12'h138, 1'b0, 8'h00);
        check_reg("stopped", 32'((5 * 25 + 16) / 32), rd);
        apb(12'h10c, 1'b1, 8'h58);
        apb(12'h138, 1'b0, 8'h00);
        check_reg("cleared", 32'h0, rd);
        apb(12'h120, 1'b0, 8'h00);
        check_reg("minutes kept", 32'h0, rd);
        complete_run;
    end
endmodule
